/* File: rtl/dlpc_ctrl.sv */
// Host-side low-power controller for a DDR4 device: power-down and self refresh sequencing.
// Assumes an APB master on clk and a device clock derived from clk outside this module.
`timescale 1ns/1ps
`include "dlpc_consts.svh"

// Contract
// - Non-abort self refresh exit waits tRFC plus 10ns.
// - Abort bit off means normal exit delay.
// - Abort mode allows commands after abort delay.
// - One extra REFRESH before next self refresh.
// - NOP exit only without parity/CAL, NOPs only.
// - NOP exit never uses fast or abort delay.
// - Power-down entry is CKE low with DESELECT.
// - No CKE drop during busy operations.
// - Unlocked DLL at entry needs DLL reset.
// - DESELECT throughout CKE transition period.
// - CKE low minimum; stay under nine refresh intervals.
// - Exit with CKE high, DESELECT, wait exit latency.
// - Drive ODT valid at exit if termination on.
// - No exit before minimum power-down time.
// - Drive ODT through transition, then may float.
module dlpc_ctrl
   import dlpc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        dram_busy,
   input  wire logic        dll_locked,
   output logic             dram_cke,
   output logic             dram_reset_n,
   output logic             dram_odt,
   output logic             dram_odt_oe,
   output dlpc_cmd_s        dram_cmd
);

   function automatic logic [15:0] ns_to_cyc(input int ns);
      int c;
      c = (ns + `DLPC_CLK_NS - 1) / `DLPC_CLK_NS;
      if (c < 1) begin
         c = 1;
      end
      return c[15:0];
   endfunction

   function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
      return (a > b) ? a : b;
   endfunction

   localparam logic [15:0] TXS_CYC    = ns_to_cyc(`DLPC_TRFC_NS + `DLPC_TXS_ADD_NS);
   localparam logic [15:0] TXSA_CYC   = ns_to_cyc(`DLPC_TXS_ABORT_NS);
   localparam logic [15:0] TCKE_CYC   = ns_to_cyc(`DLPC_TCKE_NS);
   localparam logic [15:0] TXP_CYC    = max16(ns_to_cyc(`DLPC_TXP_NS), TCKE_CYC);
   localparam logic [15:0] TCPDED_CYC = 16'(`DLPC_TCPDED_NCK);
   localparam logic [15:0] TPDMAX_CYC = 16'((`DLPC_PD_MAX_REFI * `DLPC_TREFI_NS) / `DLPC_CLK_NS);
   localparam logic [3:0]  TMPX_CYC   = 4'(ns_to_cyc(`DLPC_TMPX_LH_NS));
   localparam dlpc_cmd_s   CMD_DES    = '{ctl: `DLPC_CMD_DES, addr: 14'h0000};

   dlpc_regs_s r_r;
   dlpc_regs_s r_nxt;
   logic       run;
   logic       wr_acc;
   logic       rd_setup;

   assign run      = r_r.ctrl[`DLPC_C_RUN];
   assign wr_acc   = psel && penable && pwrite && r_r.pready;
   assign rd_setup = psel && !penable;

   always_comb begin
      r_nxt         = r_r;
      r_nxt.cmd     = CMD_DES;
      r_nxt.pready  = 1'b0;
      r_nxt.pslverr = 1'b0;
      r_nxt.odt     = r_r.ctrl[`DLPC_C_ODT_LVL];
      r_nxt.odt_oe  = 1'b1;
      r_nxt.rst_n   = run;
      if (r_r.cnt != 16'h0000) begin
         r_nxt.cnt = r_r.cnt - 16'h0001;
      end

      // Register access: answer in the access cycle, one cycle after setup.
      if (rd_setup) begin
         r_nxt.pready = 1'b1;
         case (paddr)
            `DLPC_OFF_CTRL: r_nxt.prdata = {23'h000000, r_r.ctrl};
            `DLPC_OFF_CMD:  r_nxt.prdata = {13'h0000, r_r.pend_cmd.addr, r_r.pend_cmd.ctl};
            `DLPC_OFF_STAT: r_nxt.prdata = {24'h000000, r_r.fsm, r_r.cke, r_r.pend,
                                            r_r.dll_rst_need, r_r.ref_owed, r_r.nop_x};
            default: begin
               r_nxt.prdata  = 32'h00000000;
               r_nxt.pslverr = 1'b1;
            end
         endcase
      end
      if (wr_acc) begin
         case (paddr)
            `DLPC_OFF_CTRL: r_nxt.ctrl = pwdata[`DLPC_CTRL_W-1:0];
            `DLPC_OFF_CMD: begin
               // A second order while one waits is dropped; software polls the pending bit.
               if (!r_r.pend) begin
                  r_nxt.pend          = 1'b1;
                  r_nxt.pend_cmd.ctl  = pwdata[4:0];
                  r_nxt.pend_cmd.addr = pwdata[18:5];
               end
            end
            `DLPC_OFF_STAT: begin
               if (pwdata[`DLPC_S_DLL_RST]) begin
                  r_nxt.dll_rst_need = 1'b0;
               end
            end
            default: ;
         endcase
      end

      case (r_r.fsm)
         ST_IDLE: begin
            r_nxt.cke = run;
            if (r_r.pend && run) begin
               r_nxt.cmd  = r_r.pend_cmd;
               r_nxt.pend = 1'b0;
               if (r_r.pend_cmd.ctl == `DLPC_CMD_REF) begin
                  r_nxt.ref_owed = 1'b0;
               end
            end else if (run && !dram_busy && r_r.ctrl[`DLPC_C_SR_REQ] && !r_r.ref_owed) begin
               r_nxt.cke     = 1'b0;
               r_nxt.cmd.ctl = `DLPC_CMD_REF;
               r_nxt.fsm     = ST_SR;
               r_nxt.cnt     = TCKE_CYC;
            end else if (run && !dram_busy && r_r.ctrl[`DLPC_C_PD_REQ]) begin
               r_nxt.cke          = 1'b0;
               r_nxt.fsm          = ST_PDE;
               r_nxt.cnt          = TCPDED_CYC;
               r_nxt.pdcnt        = TPDMAX_CYC;
               r_nxt.dll_at_entry = dll_locked;
            end
         end
         ST_PDE: begin
            // DESELECT and valid ODT are held while the CKE change settles.
            r_nxt.pdcnt = r_r.pdcnt - 16'h0001;
            if (r_r.cnt == 16'h0001) begin
               r_nxt.fsm = ST_PD;
               r_nxt.cnt = TCKE_CYC - TCPDED_CYC;
            end
         end
         ST_PD: begin
            if (r_r.pdcnt != 16'h0000) begin
               r_nxt.pdcnt = r_r.pdcnt - 16'h0001;
            end
            if (!run) begin
               r_nxt.fsm = ST_IDLE;
               r_nxt.cke = 1'b0;
            end else if (r_r.cnt <= 16'h0001 &&
                         (!r_r.ctrl[`DLPC_C_PD_REQ] || r_r.pdcnt <= 16'h0001)) begin
               r_nxt.cke = 1'b1;
               r_nxt.fsm = ST_PDX;
               r_nxt.cnt = TXP_CYC;
            end else begin
               r_nxt.odt_oe = !r_r.ctrl[`DLPC_C_ODT_BUF_DIS];
            end
         end
         ST_PDX: begin
            // ODT is driven again from the exit edge on.
            if (r_r.cnt == 16'h0001) begin
               r_nxt.fsm = ST_IDLE;
               if (!r_r.dll_at_entry) begin
                  r_nxt.dll_rst_need = 1'b1;
               end
            end
         end
         ST_SR: begin
            r_nxt.odt_oe = 1'b1;
            if (!run) begin
               r_nxt.fsm = ST_IDLE;
               r_nxt.cke = 1'b0;
            end else if (r_r.cnt <= 16'h0001 && !r_r.ctrl[`DLPC_C_SR_REQ]) begin
               r_nxt.cke      = 1'b1;
               r_nxt.fsm      = ST_SRX;
               r_nxt.ref_owed = 1'b1;
               r_nxt.nop_x    = r_r.ctrl[`DLPC_C_NOP_EXIT] && !r_r.ctrl[`DLPC_C_PAR_CAL_ON];
               r_nxt.mpx      = TMPX_CYC;
               // NOP exit always takes the full delay.
               if (r_r.ctrl[`DLPC_C_ABORT_EN] &&
                   !(r_r.ctrl[`DLPC_C_NOP_EXIT] && !r_r.ctrl[`DLPC_C_PAR_CAL_ON])) begin
                  r_nxt.cnt = TXSA_CYC;
               end else begin
                  r_nxt.cnt = TXS_CYC;
               end
               if (r_r.ctrl[`DLPC_C_NOP_EXIT] && !r_r.ctrl[`DLPC_C_PAR_CAL_ON]) begin
                  r_nxt.cmd.ctl = `DLPC_CMD_NOP;
               end
            end
         end
         ST_SRX: begin
            if (r_r.mpx != 4'h0) begin
               r_nxt.mpx = r_r.mpx - 4'h1;
            end
            if (r_r.nop_x && r_r.mpx > 4'h1) begin
               r_nxt.cmd.ctl = `DLPC_CMD_NOP;
            end
            if (r_r.cnt <= 16'h0001 && (!r_r.nop_x || r_r.mpx <= 4'h1)) begin
               r_nxt.fsm   = ST_IDLE;
               r_nxt.nop_x = 1'b0;
            end
         end
         default: r_nxt.fsm = ST_IDLE;
      endcase
      if (!run) begin
         // Reset held low: CKE low, no low-power state survives.
         r_nxt.cke = 1'b0;
         r_nxt.fsm = ST_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         r_r          <= '0;
         r_r.fsm      <= ST_IDLE;
         r_r.cmd      <= CMD_DES;
         r_r.pend_cmd <= CMD_DES;
         r_r.odt_oe   <= 1'b1;
         r_r.ctrl     <= `DLPC_CTRL_RST;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign prdata       = r_r.prdata;
   assign pready       = r_r.pready;
   assign pslverr      = r_r.pslverr;
   assign dram_cke     = r_r.cke;
   assign dram_reset_n = r_r.rst_n;
   assign dram_odt     = r_r.odt;
   assign dram_odt_oe  = r_r.odt_oe;
   assign dram_cmd     = r_r.cmd;

   // Helper: cycles CKE has been low, saturating.
   logic [15:0] low_cnt;
   always_ff @(posedge clk) begin
      if (srst || r_r.cke) begin
         low_cnt <= 16'h0000;
      end else if (low_cnt != 16'hffff) begin
         low_cnt <= low_cnt + 16'h0001;
      end
   end

   default clocking dflt_cb @(posedge clk); endclocking
   default disable iff (srst);

   AST_PDE_DES: assert property (r_r.fsm == ST_PDE |-> !r_r.cke && r_r.cmd.ctl == `DLPC_CMD_DES)
      else $error("power-down entry without CKE low and deselect");
   AST_BUSY_HOLD: assert property (r_r.fsm == ST_IDLE && r_r.cke && dram_busy && run
                                   |=> r_r.cke)
      else $error("CKE dropped while busy");
   AST_PD_MIN: assert property ($rose(r_r.cke) && $past(r_r.fsm) == ST_PD
                               |-> low_cnt >= TCKE_CYC && $past(low_cnt) >= TCKE_CYC - 16'h0001)
      else $error("power-down left before minimum time");
   AST_PDX_DES: assert property ($rose(r_r.fsm == ST_PDX) |-> r_r.cmd.ctl == `DLPC_CMD_DES
                                 [*5])
      else $error("command during power-down exit latency");
   AST_SRX_GAP: assert property ($rose(r_r.fsm == ST_SRX) |-> r_r.cnt ==
                                 ((r_r.nop_x || !r_r.ctrl[`DLPC_C_ABORT_EN]) ? TXS_CYC : TXSA_CYC))
      else $error("wrong self refresh exit delay");
   AST_ABORT_NOP: assert property ($rose(r_r.fsm == ST_SRX) && r_r.nop_x |-> r_r.cnt == TXS_CYC)
      else $error("NOP exit used a short delay");
   AST_REF_OWED: assert property ($rose(r_r.fsm == ST_SR) |-> !$past(r_r.ref_owed))
      else $error("self refresh re-entered without extra refresh");
   AST_NOP_ONLY: assert property (r_r.fsm == ST_SRX && !r_r.nop_x |-> r_r.cmd.ctl == `DLPC_CMD_DES)
      else $error("non-deselect during normal self refresh exit");
   AST_ODT_DRIVE: assert property (r_r.fsm != ST_PD |-> r_r.odt_oe)
      else $error("ODT released outside power-down");
   AST_PD_MAX: assert property (r_r.fsm == ST_PD && run && r_r.pdcnt <= 16'h0001 && r_r.cnt <= 16'h0001
                                |=> r_r.fsm == ST_PDX ##1 r_r.cke)
      else $error("power-down stay exceeded");
   AST_DLL_RST: assert property ($fell(r_r.fsm == ST_PDX) && !$past(r_r.dll_at_entry)
                                 && $past(run) |-> r_r.dll_rst_need)
      else $error("DLL reset need not flagged");

   COV_PD_TRIP: cover property (r_r.fsm == ST_PD ##[1:800] r_r.fsm == ST_PDX ##[1:10] r_r.fsm == ST_IDLE);
   COV_SR_ABORT: cover property ($rose(r_r.fsm == ST_SRX) && r_r.cnt == TXSA_CYC);
   COV_SR_NOP: cover property (r_r.fsm == ST_SRX && r_r.cmd.ctl == `DLPC_CMD_NOP);
   COV_PD_FORCED: cover property (r_r.fsm == ST_PD && r_r.ctrl[`DLPC_C_PD_REQ] ##1 r_r.fsm == ST_PDX);

endmodule // dlpc_ctrl

/* File: inc/dlpc_consts.svh */
// Offsets, field positions, reset values and timing figures of the low-power controller.
// Assumes a 100 ns system clock that also serves as the memory clock reference.
`ifndef DLPC_CONSTS_SVH
`define DLPC_CONSTS_SVH

`define DLPC_CLK_NS        100
`define DLPC_OFF_CTRL      8'h00
`define DLPC_OFF_CMD       8'h04
`define DLPC_OFF_STAT      8'h08
`define DLPC_CTRL_RST      9'h000
`define DLPC_CTRL_W        9

`define DLPC_C_PD_REQ      0
`define DLPC_C_SR_REQ      1
`define DLPC_C_ABORT_EN    2
`define DLPC_C_ODT_BUF_DIS 3
`define DLPC_C_RTT_NOM_EN  4
`define DLPC_C_NOP_EXIT    5
`define DLPC_C_PAR_CAL_ON  6
`define DLPC_C_ODT_LVL     7
`define DLPC_C_RUN         8
`define DLPC_S_DLL_RST     2

`define DLPC_CMD_DES       5'h1f
`define DLPC_CMD_NOP       5'h0f
`define DLPC_CMD_REF       5'h09

`define DLPC_TRFC_NS       260
`define DLPC_TXS_ADD_NS    10
`define DLPC_TXS_ABORT_NS  170
`define DLPC_TCKE_NS       500
`define DLPC_TXP_NS        600
`define DLPC_TREFI_NS      7800
`define DLPC_PD_MAX_REFI   9
`define DLPC_TCPDED_NCK    4
`define DLPC_TMPX_LH_NS    1000

`endif

/* File: inc/dlpc_pkg.sv */
// Types shared by the low-power controller: states, command pins and the state record.
// Assumes dlpc_consts.svh for every figure.
package dlpc_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_PDE, ST_PD, ST_PDX, ST_SR, ST_SRX} dlpc_state_e;

   typedef struct packed {
      logic [4:0]  ctl;
      logic [13:0] addr;
   } dlpc_cmd_s;

   typedef struct packed {
      dlpc_state_e fsm;
      logic [15:0] cnt;
      logic [15:0] pdcnt;
      logic [3:0]  mpx;
      logic        nop_x;
      logic        cke;
      logic        rst_n;
      logic        odt;
      logic        odt_oe;
      dlpc_cmd_s   cmd;
      logic [8:0]  ctrl;
      dlpc_cmd_s   pend_cmd;
      logic        pend;
      logic        ref_owed;
      logic        dll_rst_need;
      logic        dll_at_entry;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } dlpc_regs_s;
endpackage

/* File: bench/dlpc_dev_model.sv */
// Behavioural DDR4 device partner: power-down and self refresh tracking, early-command count.
// Assumes it sees the controller's pins on the controller's own clock.
`timescale 1ns/1ps
`include "dlpc_consts.svh"
module dlpc_dev_model
   import dlpc_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      cke,
   input  wire logic      reset_n,
   input  wire logic      odt,
   input  wire logic      odt_oe,
   input  wire dlpc_cmd_s cmd,
   output logic           odt_w,
   output int             viol,
   output int             refs
);
   typedef enum logic [2:0] {D_RST, D_ACT, D_PD, D_SR} dlpc_dst_e;
   dlpc_dst_e st;
   int        cnt;
   int        gap;
   logic      odt_last;
   wire       is_des = (cmd.ctl == `DLPC_CMD_DES);
   wire       is_ref = (cmd.ctl == `DLPC_CMD_REF);
   wire       idle_c = is_des || (cmd.ctl == `DLPC_CMD_NOP);
   // A released ODT line shows the opposite of its last driven level, never a settled copy.
   assign odt_w = odt_oe ? odt : ~odt_last;
   initial begin
      viol = 0; refs = 0; st = D_RST; cnt = 0; gap = 0; odt_last = 1'b0;
   end
   always @(posedge clk) begin
      if (odt_oe) odt_last <= odt;
      cnt <= cnt + 1;
      if (!reset_n) begin
         st <= D_RST;
      end else begin
         case (st)
            D_RST: st <= D_ACT;
            D_ACT: begin
               if (cke && !idle_c && cnt < gap) viol <= viol + 1;
               if (!cke && is_des) begin
                  st <= D_PD; cnt <= 1;
               end else if (!cke && is_ref) begin
                  st <= D_SR; cnt <= 1;
               end else if (cke && is_ref) begin
                  refs <= refs + 1;
               end
            end
            D_PD: begin
               // Commands after the first DLPC_TCPDED_NCK cycles are ignored because the receivers are off.
               if (cnt <= `DLPC_TCPDED_NCK && !is_des) viol <= viol + 1;
               if (cke) begin
                  if (!is_des || !odt_oe || cnt < 5) viol <= viol + 1;
                  st <= D_ACT; cnt <= 0; gap <= 6;
               end
            end
            D_SR: if (cke) begin
               // An aborted internal refresh leaves the counter as it was.
               st <= D_ACT; cnt <= 0; gap <= 2;
            end
            default: st <= D_RST;
         endcase
      end
   end
endmodule // dlpc_dev_model

/* File: bench/dlpc_ctrl_tb.sv */
// Self-checking bench of the low-power controller with a device partner on its pins.
// Assumes dlpc_ctrl's APB answers in the access cycle and a 100 ns clock.
`timescale 1ns/1ps
`include "dlpc_consts.svh"
module dlpc_ctrl_tb import dlpc_pkg::*; ;
   localparam int TCK = `DLPC_CLK_NS;
   localparam int TXS = (`DLPC_TRFC_NS + `DLPC_TXS_ADD_NS + TCK - 1) / TCK;
   localparam int TXA = (`DLPC_TXS_ABORT_NS + TCK - 1) / TCK;
   localparam int TCKE = (`DLPC_TCKE_NS + TCK - 1) / TCK;
   localparam int PDMAX = `DLPC_PD_MAX_REFI * `DLPC_TREFI_NS / TCK;
   localparam logic [31:0] RUN = 32'h1 << `DLPC_C_RUN;
   localparam logic [31:0] PD = 32'h1 << `DLPC_C_PD_REQ;
   localparam logic [31:0] SR = 32'h1 << `DLPC_C_SR_REQ;
   localparam logic [31:0] BUFD = 32'h1 << `DLPC_C_ODT_BUF_DIS;
   localparam logic [31:0] MODE [4] = '{32'h0, 32'h4, 32'h20, 32'h60};
   logic        clk, srst, psel, penable, pwrite, pready, pslverr, erv;
   logic        dram_busy, dll_locked, dram_cke, dram_reset_n, dram_odt, dram_odt_oe, pcke;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdv, v;
   logic [15:0] seed;
   dlpc_cmd_s   dram_cmd;
   int          mismatches, checked, viol, refs, r0, n0, lowc, min_low, max_low, bad_oe;
   int          hic, last_gap, nops;
   int          gap [4];
   dlpc_ctrl u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dram_busy(dram_busy), .dll_locked(dll_locked), .dram_cke(dram_cke),
      .dram_reset_n(dram_reset_n), .dram_odt(dram_odt), .dram_odt_oe(dram_odt_oe),
      .dram_cmd(dram_cmd));
   dlpc_dev_model u_dev (.clk(clk), .cke(dram_cke), .reset_n(dram_reset_n), .odt(dram_odt),
      .odt_oe(dram_odt_oe), .cmd(dram_cmd), .odt_w(), .viol(viol), .refs(refs));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask
   task automatic end_of_test();
      if (mismatches == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Read data and error flag are taken at the rising edge at which pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
      if (n >= 50) chk(1'b0, "no pready");
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
   task automatic rd(input logic [7:0] a); apb(1'b0, a, 32'h0); endtask
   task automatic wait_cke(input logic lv);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (dram_cke !== lv && n < 2000);
      @(posedge clk);
      if (n >= 2000) chk(1'b0, "cke wait");
   endtask
   initial begin
      clk = 1'b0;
      forever #(TCK / 2) clk = ~clk;
   end
   always @(posedge clk) begin
      if (dram_reset_n !== 1'b1) begin
         lowc = 0;
      end else if (dram_cke === 1'b0) begin
         if (lowc < `DLPC_TCPDED_NCK && dram_odt_oe !== 1'b1) bad_oe++;
         lowc++;
      end else begin
         if (lowc > 0 && lowc < min_low) min_low = lowc;
         if (lowc > max_low) max_low = lowc;
         lowc = 0;
      end
      if (dram_cke === 1'b1 && pcke !== 1'b1) hic = 0;
      else hic++;
      if (dram_cke === 1'b1 && dram_cmd.ctl !== `DLPC_CMD_DES && dram_cmd.ctl !== `DLPC_CMD_NOP)
         last_gap = hic;
      if (dram_cmd.ctl === `DLPC_CMD_NOP) nops++;
      pcke = dram_cke;
   end
   initial begin
      #(TCK * 20000);
      mismatches++;
      end_of_test();
   end
   initial begin
      srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      dram_busy = 1'b0; dll_locked = 1'b1; seed = 16'h005b; mismatches = 0; checked = 0;
      lowc = 0; min_low = 100000; max_low = 0; bad_oe = 0; hic = 0; last_gap = 0; nops = 0;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      chk(dram_cke === 1'b0 && dram_reset_n === 1'b0 && dram_odt_oe === 1'b1, "reset pins");
      chk(dram_cmd.ctl === `DLPC_CMD_DES, "reset command");
      @(posedge clk);
      rd(`DLPC_OFF_CTRL); chk(rdv === 32'h0, "ctrl reset value");
      rd(`DLPC_OFF_STAT); chk(rdv === 32'h0, "stat reset value");
      rd(8'h0c); chk(erv === 1'b1 && rdv === 32'h0, "unmapped read");
      seed = lfsr(seed);
      v = RUN | ({16'h0, seed} & 32'h0f8);
      wr(`DLPC_OFF_CTRL, v); rd(`DLPC_OFF_CTRL); chk(rdv === v, "ctrl readback");
      chk(dram_reset_n === 1'b1 && dram_odt === v[`DLPC_C_ODT_LVL], "run pins");
      r0 = refs;
      v = {13'h0, seed[13:0], 5'h09};
      wr(`DLPC_OFF_CMD, v); rd(`DLPC_OFF_CMD); chk(rdv === v, "cmd readback");
      chk(refs === r0 + 1, "queued refresh");
      dll_locked <= 1'b0; dram_busy <= 1'b1;
      wr(`DLPC_OFF_CTRL, RUN | BUFD | 32'h90 | PD);
      seed = lfsr(seed);
      repeat (4 + seed[3:0]) begin
         @(negedge clk);
         chk(dram_cke === 1'b1, "cke dropped while busy");
      end
      @(posedge clk);
      dram_busy <= 1'b0;
      wait_cke(1'b0);
      wait_cke(1'b1);
      @(posedge clk);
      chk(max_low >= PDMAX && max_low <= PDMAX + 6, "power-down stay limit");
      wait_cke(1'b0);
      repeat (6) @(posedge clk);
      chk(dram_odt_oe === 1'b0, "odt released in power-down");
      rd(`DLPC_OFF_STAT); chk(rdv[7:5] === 3'd2 && rdv[2] === 1'b1, "pd status");
      dll_locked <= 1'b1;
      wr(`DLPC_OFF_CTRL, RUN | BUFD);
      wait_cke(1'b1);
      chk(dram_odt_oe === 1'b1, "odt driven at exit");
      repeat (8) @(posedge clk);
      wr(`DLPC_OFF_STAT, 32'h4); rd(`DLPC_OFF_STAT);
      chk(rdv[2] === 1'b0 && rdv[7:5] === 3'd0, "dll flag clear");
      wr(`DLPC_OFF_CTRL, RUN | PD);
      wait_cke(1'b0);
      repeat (6) @(posedge clk);
      chk(dram_odt_oe === 1'b1, "odt kept without buffer disable");
      wr(`DLPC_OFF_CTRL, 32'h0);
      @(posedge clk);
      chk(dram_reset_n === 1'b0 && dram_cke === 1'b0, "reset in power-down");
      wr(`DLPC_OFF_CTRL, RUN);
      for (int m = 0; m < 4; m++) begin
         n0 = nops;
         wr(`DLPC_OFF_CTRL, RUN | SR | MODE[m]);
         wait_cke(1'b0);
         wr(`DLPC_OFF_CMD, 32'h9);
         repeat (TCKE) @(posedge clk);
         wr(`DLPC_OFF_CTRL, RUN | MODE[m]);
         wait_cke(1'b1);
         repeat (20) @(posedge clk);
         gap[m] = last_gap;
         chk((nops > n0) === (m == 2), "nop exit use");
      end
      chk(gap[0] - gap[1] === TXS - TXA, "abort exit shorter");
      chk(gap[1] >= TXA, "abort exit delay");
      chk(gap[2] >= gap[0] && gap[3] === gap[0], "nop exit delay");
      chk(gap[2] > `DLPC_TMPX_LH_NS / TCK, "command inside nop window");
      wr(`DLPC_OFF_CTRL, RUN | SR);
      wait_cke(1'b0);
      repeat (TCKE) @(posedge clk);
      wr(`DLPC_OFF_CTRL, RUN);
      wait_cke(1'b1);
      repeat (8) @(posedge clk);
      rd(`DLPC_OFF_STAT); chk(rdv[1] === 1'b1, "refresh owed");
      wr(`DLPC_OFF_CTRL, RUN | SR);
      repeat (20) begin
         @(negedge clk);
         chk(dram_cke === 1'b1, "self refresh while owed");
      end
      @(posedge clk);
      r0 = refs;
      wr(`DLPC_OFF_CMD, 32'h9);
      wait_cke(1'b0);
      chk(refs === r0 + 1, "refresh before re-entry");
      wr(`DLPC_OFF_CTRL, RUN);
      wait_cke(1'b1);
      repeat (20) @(posedge clk);
      chk(bad_oe === 0, "odt released too early");
      chk(min_low >= TCKE, "cke low too short");
      chk(viol === 0, "device saw early command");
      end_of_test();
   end
endmodule // dlpc_ctrl_tb
